/* File: rtl/sil_pkg.sv */
// Purpose: Shared constants for the stepper input and stall logic.
// Assumes: One 40 MHz clock; all plain-port control, no register bus.
// Notes:   Function, move type and threshold encodings live here.
package sil_pkg;
   // Clock rate
   localparam int unsigned      SIL_CLOCK_HZ   = 40000000;
   // Discrete input count and function encoding
   localparam int unsigned      SIL_NUM_IN     = 3;
   localparam int unsigned      SIL_FUNC_W     = 3;
   localparam logic [2:0]       SIL_FN_GENERAL = 3'h0;
   localparam logic [2:0]       SIL_FN_HOME    = 3'h1;
   localparam logic [2:0]       SIL_FN_CW_LIM  = 3'h2;
   localparam logic [2:0]       SIL_FN_CCW_LIM = 3'h3;
   localparam logic [2:0]       SIL_FN_IDX_GO  = 3'h4;
   localparam logic [2:0]       SIL_FN_ESTOP   = 3'h5;
   localparam logic [2:0]       SIL_FN_JOG_STP = 3'h6;
   // Move type encoding
   localparam int unsigned      SIL_MV_W       = 3;
   localparam logic [2:0]       SIL_MV_JOG     = 3'h0;
   localparam logic [2:0]       SIL_MV_REG     = 3'h1;
   localparam logic [2:0]       SIL_MV_REL     = 3'h2;
   localparam logic [2:0]       SIL_MV_ABS     = 3'h3;
   localparam logic [2:0]       SIL_MV_IDX     = 3'h4;
   localparam logic [2:0]       SIL_MV_BLEND   = 3'h5;
   localparam logic [2:0]       SIL_MV_DWELL   = 3'h6;
   localparam logic [2:0]       SIL_MV_HOME    = 3'h7;
   // Position and stall window
   localparam int unsigned      SIL_POS_W      = 32;
   localparam logic [31:0]      SIL_STALL_DEG  = 32'h0000002d;
   localparam logic [31:0]      SIL_TURN_DEG   = 32'h00000168;
   // Current scaling, run current in tenths of an ampere
   localparam logic [5:0]       SIL_RUN_MIN_DA = 6'h01;
   localparam logic [5:0]       SIL_RUN_MAX_DA = 6'h28;
   localparam logic [6:0]       SIL_PCT_MAX    = 7'h64;
   localparam logic [15:0]      SIL_MA_PER_DA  = 16'h0064;
   // Reset values
   localparam logic             SIL_POS_VALID_RST = 1'b0;
   // Gate state machine
   typedef enum logic [1:0] {
      SIL_GATE_IDLE = 2'b01,
      SIL_GATE_PEND = 2'b10
   } sil_gate_t;
endpackage : sil_pkg

/* File: rtl/sil_input_cond.sv */
// Purpose: Synchronise one discrete input, apply polarity, find edges.
// Assumes: Raw pin level is high when the contact is closed.
// Notes:   Edge pulses are one cycle wide and align with the level.
`timescale 1ns/1ps
`default_nettype none
module sil_input_cond (
   // Clock and reset
   input  wire logic clock,
   input  wire logic rst_n,
   // Pin and polarity
   input  wire logic raw,
   input  wire logic active_closed,
   // Conditioned view
   output var  logic level,
   output var  logic rise,
   output var  logic any_edge
);
   logic       sync_a;   // First stage, read only by sync_b
   logic       sync_b;   // Second stage
   logic       active;   // Polarity-corrected level
   logic [2:0] warm;     // Fills after reset; edges wait for it

   // Edges held off until synchroniser and level carry real pin data,
   // else an open-is-active pin would fake an edge just after reset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         warm <= 3'h0;
      end else begin
         warm <= {warm[1:0], 1'b1};
      end
   end

   // Two-flop synchroniser against metastability
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
      end else begin
         sync_a <= raw;
         sync_b <= sync_a;
      end
   end

   // Polarity applied before edges so each function sees one event
   always_comb begin
      active = active_closed ? sync_b : ~sync_b;
   end

   // Level and edge pulses
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level    <= 1'b0;
         rise     <= 1'b0;
         any_edge <= 1'b0;
      end else begin
         level    <= active;
         rise     <= warm[2] & active & ~level;
         any_edge <= warm[2] & (active ^ level);
      end
   end
endmodule : sil_input_cond
`default_nettype wire

/* File: rtl/sil_top.sv */
// Purpose: Stall supervision, current levels, protection, input use.
// Assumes: Move generator and encoder counter sit outside this block.
// Notes:   Function
`timescale 1ns/1ps
`default_nettype none
module sil_top
   import sil_pkg::*;
(
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // Discrete inputs and their setup
   input  wire logic [2:0]                   din_raw,
   input  wire logic [2:0][sil_pkg::SIL_FUNC_W-1:0] din_function,
   input  wire logic [2:0]                   din_active_closed,
   // Host configuration and commands
   input  wire logic                         stall_en,
   input  wire logic                         encoder_en,
   input  wire logic [5:0]                   run_current_da,
   input  wire logic [6:0]                   idle_pct,
   input  wire logic                         net_home_prox,
   input  wire logic                         stall_clear,
   input  wire logic                         fault_clear,
   input  wire logic                         pos_preset,
   input  wire logic                         home_done,
   // Move requests and running move
   input  wire logic                         move_req,
   input  wire logic [sil_pkg::SIL_MV_W-1:0] req_type,
   input  wire logic                         req_dir,
   input  wire logic                         move_running,
   input  wire logic [sil_pkg::SIL_MV_W-1:0] run_type,
   input  wire logic                         run_dir,
   // Measurements
   input  wire logic [sil_pkg::SIL_POS_W-1:0] enc_pos,
   input  wire logic [sil_pkg::SIL_POS_W-1:0] motor_pos,
   input  wire logic [15:0]                  counts_per_turn,
   input  wire logic [7:0]                   temp_code,
   input  wire logic [7:0]                   temp_warn_limit,
   input  wire logic [7:0]                   temp_fault_limit,
   input  wire logic                         winding_short,
   // Motion control outputs
   output var  logic                         move_start,
   output var  logic                         move_reject,
   output var  logic                         stop_immediate,
   output var  logic                         stop_controlled,
   output var  logic                         indexer_pending,
   // Capture
   output var  logic [sil_pkg::SIL_POS_W-1:0] capture_pos,
   output var  logic                         capture_strobe,
   // Status to host
   output var  logic                         stall_flag,
   output var  logic                         pos_valid,
   output var  logic                         temp_warning,
   output var  logic                         temp_fault,
   output var  logic                         short_fault,
   output var  logic [2:0]                   input_state,
   output var  logic                         home_prox,
   // Drive stage
   output var  logic                         motor_power_en,
   output var  logic [15:0]                  current_ma,
   output var  logic                         current_is_peak
);
   import sil_pkg::*;

   // Conditioned inputs
   logic [2:0]          in_level;       // Active-high levels
   logic [2:0]          in_rise;        // Inactive-to-active pulses
   logic [2:0]          in_edge;        // Either-direction pulses
   // Function views
   logic                estop_act;      // Halt input active
   logic                cw_lim;         // Clockwise limit active
   logic                ccw_lim;        // Counter-clockwise limit active
   logic                home_in;        // Home input active
   logic                idx_rise;       // Indexer start rising
   logic                idx_edge;       // Indexer start any edge
   logic                jog_rise;       // Jog-stop rising
   // Stall datapath
   logic signed [32:0]  pos_diff;       // Encoder minus motor
   logic [32:0]         pos_mag;        // Magnitude of error
   logic [31:0]         stall_thr;      // Counts in 45 degrees
   logic                stall_det;      // Error beyond window
   // Move gating
   logic                jog_like;       // Running jog or registration
   logic                limit_hit;      // Limit in running direction
   logic                req_blocked;    // Request would be refused
   logic                pend_dir;       // Direction of armed move
   logic                pend_blocked;   // Armed move cannot run now
   sil_gate_t           gate_state;     // Indexer gate state
   // Current scaling
   logic [5:0]          run_c;          // Clamped run current
   logic [6:0]          pct_c;          // Clamped idle percent
   logic                next_power;     // Power enable next cycle

   // One conditioner per discrete input
   for (genvar i = 0; i < SIL_NUM_IN; i++) begin : g_in
      sil_input_cond u_cond (
         .clock         (clock),
         .rst_n         (rst_n),
         .raw           (din_raw[i]),
         .active_closed (din_active_closed[i]),
         .level         (in_level[i]),
         .rise          (in_rise[i]),
         .any_edge      (in_edge[i])
      );
   end

   // Fold per-input functions into named events
   always_comb begin
      estop_act = 1'b0;
      cw_lim    = 1'b0;
      ccw_lim   = 1'b0;
      home_in   = 1'b0;
      idx_rise  = 1'b0;
      idx_edge  = 1'b0;
      jog_rise  = 1'b0;
      for (int k = 0; k < SIL_NUM_IN; k++) begin
         unique case (din_function[k])
            SIL_FN_ESTOP:   estop_act = estop_act | in_level[k];
            SIL_FN_CW_LIM:  cw_lim    = cw_lim | in_level[k];
            SIL_FN_CCW_LIM: ccw_lim   = ccw_lim | in_level[k];
            SIL_FN_HOME:    home_in   = home_in | in_level[k];
            SIL_FN_IDX_GO: begin
               idx_rise = idx_rise | in_rise[k];
               idx_edge = idx_edge | in_edge[k];
            end
            SIL_FN_JOG_STP: jog_rise  = jog_rise | in_rise[k];
            // General purpose and spare codes steer nothing
            default: ;
         endcase
      end
   end

   // Position error against a 45 degree window, moving or not
   always_comb begin
      pos_diff  = $signed({enc_pos[31], enc_pos}) -
                  $signed({motor_pos[31], motor_pos});
      pos_mag   = pos_diff[32] ? 33'(-pos_diff) : 33'(pos_diff);
      stall_thr = 32'(counts_per_turn) * SIL_STALL_DEG / SIL_TURN_DEG;
      stall_det = stall_en && (pos_mag > {1'b0, stall_thr});
   end

   // Move gating terms
   always_comb begin
      jog_like  = move_running &&
                  (run_type == SIL_MV_JOG || run_type == SIL_MV_REG);
      limit_hit = move_running && (run_dir ? cw_lim : ccw_lim);
      // Halt, lost position on an absolute move and blocked direction all refuse
      req_blocked = estop_act ||
                    (req_type == SIL_MV_ABS && !pos_valid) ||
                    (req_dir ? cw_lim : ccw_lim);
      pend_blocked = estop_act || (pend_dir ? cw_lim : ccw_lim);
   end

   // Sticky stall flag; a new stall wins over the host clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stall_flag <= 1'b0;
      end else if (stall_det) begin
         stall_flag <= 1'b1;
      end else if (stall_clear) begin
         stall_flag <= 1'b0;
      end
   end

   // Position validity; stall beats a same-cycle preset
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pos_valid <= SIL_POS_VALID_RST;
      end else if (stall_det) begin
         pos_valid <= 1'b0;
      end else if (pos_preset || home_done) begin
         pos_valid <= 1'b1;
      end
   end

   // Indexer gate and move start decisions
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         gate_state      <= SIL_GATE_IDLE;
         indexer_pending <= 1'b0;
         pend_dir        <= 1'b0;
         move_start      <= 1'b0;
         move_reject     <= 1'b0;
      end else begin
         move_start  <= 1'b0;
         move_reject <= 1'b0;
         unique case (gate_state)
            SIL_GATE_IDLE: begin
               if (move_req && req_blocked) begin
                  move_reject <= 1'b1;
               end else if (move_req && req_type == SIL_MV_IDX) begin
                  // Armed, waits for the start input
                  gate_state      <= SIL_GATE_PEND;
                  indexer_pending <= 1'b1;
                  pend_dir        <= req_dir;
               end else if (move_req) begin
                  move_start <= 1'b1;
               end
            end
            SIL_GATE_PEND: begin
               // Further requests are refused while armed
               if (move_req) begin
                  move_reject <= 1'b1;
               end
               if (idx_rise && !pend_blocked) begin
                  move_start      <= 1'b1;
                  gate_state      <= SIL_GATE_IDLE;
                  indexer_pending <= 1'b0;
               end
            end
         endcase
      end
   end

   // Immediate and controlled stop commands
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stop_immediate  <= 1'b0;
         stop_controlled <= 1'b0;
      end else begin
         // Held as long as the cause lasts during a move
         stop_immediate  <= move_running &&
                            (stall_det ||
                             estop_act ||
                             limit_hit);
         stop_controlled <= jog_rise && jog_like;
      end
   end

   // Encoder capture on start-input edges or jog-stop during jog or registration moves
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         capture_pos    <= '0;
         capture_strobe <= 1'b0;
      end else begin
         capture_strobe <= 1'b0;
         if (encoder_en && (idx_edge ||
                            (jog_rise && jog_like))) begin
            capture_pos    <= enc_pos;
            capture_strobe <= 1'b1;
         end
      end
   end

   // Protection faults, latched; a live cause wins over clear
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         short_fault  <= 1'b0;
         temp_fault   <= 1'b0;
         temp_warning <= 1'b0;
      end else begin
         if (winding_short) begin
            short_fault <= 1'b1;
         end else if (fault_clear) begin
            short_fault <= 1'b0;
         end
         if (temp_code > temp_fault_limit) begin
            temp_fault <= 1'b1;
         end else if (fault_clear) begin
            temp_fault <= 1'b0;
         end
         // Warning tracks the temperature, no latch needed
         temp_warning <= (temp_code > temp_warn_limit);
      end
   end

   // Clamp the programmed levels into their legal ranges
   always_comb begin
      if (run_current_da < SIL_RUN_MIN_DA) begin
         run_c = SIL_RUN_MIN_DA;
      end else if (run_current_da > SIL_RUN_MAX_DA) begin
         run_c = SIL_RUN_MAX_DA;
      end else begin
         run_c = run_current_da;
      end
      pct_c = (idle_pct > SIL_PCT_MAX) ? SIL_PCT_MAX : idle_pct;
      // Power drops on faults or a zero idle level between moves
      next_power = !(short_fault || winding_short) &&
                   !(temp_fault || (temp_code > temp_fault_limit)) &&
                   !(!move_running && pct_c == 7'h00);
   end

   // Current setpoint; idle is a peak target, 0.1 A times percent = mA
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         current_ma      <= '0;
         current_is_peak <= 1'b0;
         motor_power_en  <= 1'b0;
      end else begin
         motor_power_en <= next_power;
         if (move_running) begin
            current_ma      <= 16'(run_c) * SIL_MA_PER_DA;
            current_is_peak <= 1'b0;
         end else begin
            current_ma      <= 16'(run_c) * 16'(pct_c);
            current_is_peak <= 1'b1;
         end
      end
   end

   // Input report and home qualifier
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         input_state <= 3'h0;
         home_prox   <= 1'b0;
      end else begin
         input_state <= in_level;
         home_prox   <= home_in || net_home_prox;
      end
   end

   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   stall_flag_set_a: assert property (stall_det |=> stall_flag)
      else $error("stall not flagged");
   pos_invalid_a: assert property (stall_det |=> !pos_valid)
      else $error("position stayed valid after stall");
   abs_refuse_a: assert property (
      move_req && req_type == SIL_MV_ABS && !pos_valid
      |=> move_reject && (!move_start || $past(indexer_pending)))
      else $error("absolute move started without valid position");
   stall_stop_a: assert property (
      stall_det && move_running |=> stop_immediate)
      else $error("running move not stopped on stall");
   idle_unpower_a: assert property (
      !move_running && idle_pct == 7'h00 |=> !motor_power_en)
      else $error("motor powered at zero idle level");
   short_power_a: assert property (
      winding_short |=> !motor_power_en && short_fault)
      else $error("power kept after winding short");
   temp_cut_a: assert property (
      temp_code > temp_fault_limit |=> !motor_power_en && temp_fault)
      else $error("power kept above temperature limit");
   temp_warn_a: assert property (
      temp_code > temp_warn_limit |=> temp_warning)
      else $error("temperature warning missing");
   estop_start_a: assert property (
      estop_act |=> !move_start)
      else $error("move started during emergency halt");
   jog_stop_a: assert property (
      stop_controlled |-> $past(jog_like) && $past(jog_rise))
      else $error("controlled stop outside jog or registration");
   idle_peak_a: assert property (
      !move_running |=> current_is_peak &&
      current_ma == 16'($past(run_c)) * 16'($past(pct_c)))
      else $error("idle current not peak scaled");

   stall_seen_c: cover property (stall_det && move_running ##1 stop_immediate);
   index_go_c: cover property (indexer_pending ##[1:20] move_start);
   capture_c: cover property (capture_strobe && jog_like);
   ctrl_stop_c: cover property (stop_controlled);
endmodule : sil_top
`default_nettype wire

/* File: dv/sil_mover_model.sv */
// Purpose: Move generator stand-in at the far side of the block.
// Assumes: A move runs a fixed count of cycles unless stopped.
// Notes:   Any stop from the block ends the move at the next edge.
`timescale 1ns/1ps
`default_nettype none
module sil_mover_model
   import sil_pkg::*;
#(parameter int RUN_CYCLES = 40)
(
   // Clock and reset
   input  wire logic                         clock,
   input  wire logic                         rst_n,
   // Commands from the block
   input  wire logic                         move_start,
   input  wire logic                         stop_now,
   input  wire logic [sil_pkg::SIL_MV_W-1:0] req_type,
   input  wire logic                         req_dir,
   // Running move seen by the block
   output var  logic                         move_running,
   output var  logic [sil_pkg::SIL_MV_W-1:0] run_type,
   output var  logic                         run_dir
);
   logic [7:0] left;  // Cycles left in the move
   // Start on command; a short fixed run keeps the bench quick
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         move_running <= 1'b0;
         run_type     <= 3'h0;
         run_dir      <= 1'b0;
         left         <= 8'h00;
      end else if (move_start) begin
         move_running <= 1'b1;
         run_type     <= req_type;
         run_dir      <= req_dir;
         left         <= 8'(RUN_CYCLES);
      end else if (stop_now || left == 8'h00) begin
         move_running <= 1'b0;
      end else begin
         left <= left - 8'h01;
      end
   end
endmodule : sil_mover_model
`default_nettype wire

/* File: dv/sil_top_tb.sv */
// Purpose: Self-checking bench for the stepper input and stall logic.
// Assumes: Inputs change at the falling edge; pulses caught by monitors.
// Notes:   Pin effects take four edges, so pin steps wait six.
`timescale 1ns/1ps
`default_nettype none
module sil_top_tb;
   import sil_pkg::*;
   // Stimulus, all set at time zero
   logic             clock = 1'b0, rst_n = 1'b0, stall_en = 1'b0;
   logic [2:0]       din_raw = 3'h4, din_active_closed = 3'h3;
   logic [2:0][2:0]  din_function = {SIL_FN_JOG_STP, SIL_FN_IDX_GO, 3'h0};
   logic             encoder_en = 1'b1, net_home_prox = 1'b0;
   logic             stall_clear = 1'b0, fault_clear = 1'b0;
   logic             pos_preset = 1'b0, home_done = 1'b0, move_req = 1'b0;
   logic             req_dir = 1'b0, winding_short = 1'b0;
   logic [5:0]       run_current_da = 6'h28;
   logic [6:0]       idle_pct = 7'h19;
   logic [2:0]       req_type = 3'h0;
   logic [31:0]      enc_pos = 32'h0, motor_pos = 32'h0;
   logic [15:0]      counts_per_turn = 16'h0168;
   logic [7:0]       temp_code = 8'h20, temp_warn_limit = 8'h64;
   logic [7:0]       temp_fault_limit = 8'h96;
   // Observed outputs
   logic             move_start, move_reject, stop_immediate;
   logic             stop_controlled, indexer_pending, capture_strobe;
   logic             stall_flag, pos_valid, temp_warning, temp_fault;
   logic             short_fault, home_prox, motor_power_en;
   logic             current_is_peak, move_running, run_dir;
   logic [2:0]       input_state, run_type;
   logic [31:0]      capture_pos;
   logic [15:0]      current_ma;
   // Pulse catchers and tallies
   logic             got_s, got_r, got_c, got_sc, got_si;
   int               n_fail = 0, checks = 0, cycles = 0;
   sil_top dut (.clock, .rst_n, .din_raw, .din_function, .din_active_closed,
      .stall_en, .encoder_en, .run_current_da, .idle_pct, .net_home_prox,
      .stall_clear, .fault_clear, .pos_preset, .home_done, .move_req,
      .req_type, .req_dir, .move_running, .run_type, .run_dir, .enc_pos,
      .motor_pos, .counts_per_turn, .temp_code, .temp_warn_limit,
      .temp_fault_limit, .winding_short, .move_start, .move_reject,
      .stop_immediate, .stop_controlled, .indexer_pending, .capture_pos,
      .capture_strobe, .stall_flag, .pos_valid, .temp_warning, .temp_fault,
      .short_fault, .input_state, .home_prox, .motor_power_en, .current_ma,
      .current_is_peak);
   sil_mover_model #(.RUN_CYCLES(40)) mover (.clock, .rst_n, .move_start,
      .stop_now(stop_immediate | stop_controlled), .req_type, .req_dir,
      .move_running, .run_type, .run_dir);
   // Free running clock
   always #12.5 clock = ~clock;
   // Latch one-cycle pulses so checks need not hit the exact cycle
   always @(posedge clock) begin
      if (move_start === 1'b1) got_s <= 1'b1;
      if (move_reject === 1'b1) got_r <= 1'b1;
      if (capture_strobe === 1'b1) got_c <= 1'b1;
      if (stop_controlled === 1'b1) got_sc <= 1'b1;
      if (stop_immediate === 1'b1) got_si <= 1'b1;
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic clr();
      {got_s, got_r, got_c, got_sc, got_si} = 5'h0;
   endtask : clr
   // One-cycle request, then time for the answer to land
   task automatic req(input logic [2:0] t, input logic d);
      clr();
      req_type = t;
      req_dir  = d;
      move_req = 1'b1;
      tick(1);
      move_req = 1'b0;
      tick(3);
   endtask : req
   // Pin change, long enough for sync and edge detection
   task automatic pin(input int i, input logic v);
      clr();
      din_raw[i] = v;
      tick(6);
   endtask : pin
   task automatic tally_and_finish();
      if (n_fail == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : tally_and_finish
   initial begin
      tick(20);
      rst_n = 1'b1;
      tick(2);
      chk(pos_valid, 0);
      req(SIL_MV_ABS, 1'b1);
      chk(got_r, 1);
      pos_preset = 1'b1;
      tick(1);
      pos_preset = 1'b0;
      req(SIL_MV_ABS, 1'b1);
      chk(got_s, 1);
      chk(current_ma, 32'hfa0);
      chk(current_is_peak, 0);
      tick(45);
      chk(current_ma, 32'h3e8);
      chk(current_is_peak, 1);
      run_current_da = 6'h00;
      tick(3);
      chk(current_ma, 32'h19);
      run_current_da = 6'h28;
      // Indexer armed, started and captured by the start pin
      req(SIL_MV_IDX, 1'b1);
      chk({got_s, indexer_pending}, 2'h1);
      enc_pos = 32'h123;
      pin(1, 1'b1);
      chk({got_s, got_c, indexer_pending}, 3'h6);
      chk(capture_pos, 32'h123);
      tick(45);
      enc_pos = 32'h77;
      pin(1, 1'b0);
      chk({got_s, got_c}, 2'h1);
      chk(capture_pos, 32'h77);
      // Jog stop ignored by a relative move, obeyed by jog
      req(SIL_MV_REL, 1'b0);
      pin(2, 1'b0);
      chk({got_sc, got_c}, 2'h0);
      tick(40);
      pin(2, 1'b1);
      req(SIL_MV_JOG, 1'b0);
      pin(2, 1'b0);
      chk({got_sc, got_c, move_running}, 3'h6);
      pin(2, 1'b1);
      // Halt input, then travel limit, then general purpose
      din_function[0] = SIL_FN_ESTOP;
      req(SIL_MV_REL, 1'b1);
      pin(0, 1'b1);
      chk({got_si, move_running, motor_power_en}, 3'h5);
      req(SIL_MV_REL, 1'b1);
      chk(got_r, 1);
      pin(0, 1'b0);
      din_function[0] = SIL_FN_CW_LIM;
      req(SIL_MV_REL, 1'b1);
      pin(0, 1'b1);
      chk({got_si, move_running}, 2'h2);
      req(SIL_MV_REL, 1'b1);
      chk(got_r, 1);
      req(SIL_MV_REL, 1'b0);
      chk(got_s, 1);
      tick(45);
      din_function[0] = SIL_FN_CCW_LIM;
      req(SIL_MV_REL, 1'b0);
      chk(got_r, 1);
      pin(0, 1'b0);
      din_function[0] = SIL_FN_GENERAL;
      pin(0, 1'b1);
      chk(input_state, 3'h1);
      req(SIL_MV_REL, 1'b1);
      chk(got_s, 1);
      tick(45);
      din_function[0] = SIL_FN_HOME;
      tick(2);
      chk(home_prox, 1);
      pin(0, 1'b0);
      chk(home_prox, 0);
      net_home_prox = 1'b1;
      tick(3);
      chk(home_prox, 1);
      // Start pin with nothing armed and capture switched off
      encoder_en = 1'b0;
      pin(1, 1'b1);
      chk({got_s, got_c}, 2'h0);
      encoder_en = 1'b1;
      pin(1, 1'b0);
      chk(got_c, 1);
      // Stall just inside and just over the window, during a move and at rest
      stall_en = 1'b1;
      enc_pos  = 32'h2d;
      req(SIL_MV_REL, 1'b1);
      chk(stall_flag, 0);
      enc_pos = 32'h2e;
      tick(3);
      chk({stall_flag, pos_valid}, 2'h2);
      chk({got_si, move_running}, 2'h2);
      stall_clear = 1'b1;
      tick(2);
      chk(stall_flag, 1);
      enc_pos = 32'h0;
      tick(2);
      stall_clear = 1'b0;
      tick(1);
      chk(stall_flag, 0);
      idle_pct = 7'h00;
      tick(45);
      chk(motor_power_en, 0);
      enc_pos = 32'hd0;
      tick(3);
      chk(stall_flag, 1);
      idle_pct = 7'h19;
      // Winding short and temperature protection
      winding_short = 1'b1;
      tick(3);
      chk({motor_power_en, short_fault}, 2'h1);
      winding_short = 1'b0;
      temp_code = 8'h78;
      fault_clear = 1'b1;
      tick(2);
      fault_clear = 1'b0;
      tick(2);
      chk({temp_warning, temp_fault, motor_power_en}, 3'h5);
      temp_code = 8'hc8;
      tick(3);
      chk({temp_fault, motor_power_en}, 2'h2);
      tally_and_finish();
   end
endmodule : sil_top_tb
`default_nettype wire
